// [rtl/pulser_pkg.sv]
// constants, table contents and types of the push-button pulse sequencer
// assumes a single 100 MHz system clock; shared by all design modules
package pulser_pkg;

   // system clock and the slow time base it is divided down to
   localparam int CLOCK_HZ = 100_000_000;
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_HZ = 100;
   localparam int TICK_CYCLES_DEFAULT = CLOCK_HZ / TICK_HZ;

   // one-shot output pulse width, rounded down to whole cycles
   localparam int PULSE_WIDTH_NS = 10_000;
   localparam logic [9:0] PULSE_CYCLES = 10'(PULSE_WIDTH_NS / CLK_PERIOD_NS);

   // programming windows, counted in 100 Hz ticks
   localparam logic [6:0] WINDOW_TICKS = 7'h64;
   localparam logic [6:0] HOLD_TICKS = 7'h64;
   localparam logic [6:0] ERASE_TICKS = 7'h64;

   // switch filter and indicator timing, in ticks
   localparam logic [1:0] DEBOUNCE_TICKS = 2'h2;
   localparam logic [2:0] FLASH_TICKS = 3'h5;

   // highest push count that selects a mode
   localparam logic [2:0] MAX_PUSHES = 3'h5;

   // mode table word: led period | repeat period | burst length | pulse period
   localparam int FLD_RATE_LSB = 0;
   localparam int FLD_LEN_LSB = 8;
   localparam int FLD_REPEAT_LSB = 16;
   localparam int FLD_LED_LSB = 24;
   localparam int FLD_WIDTH = 8;

   // table contents indexed by push count
   localparam logic [31:0] MODE_NONE = 32'h0000_0000;
   localparam logic [31:0] MODE_CONT_100HZ = 32'h0A00_0001;
   localparam logic [31:0] MODE_BURST_100 = 32'h00C8_6401;
   localparam logic [31:0] MODE_CONT_10HZ = 32'h1400_000A;
   localparam logic [31:0] MODE_BURST_10 = 32'h0064_0A01;
   localparam logic [31:0] MODE_CONT_1HZ = 32'h6400_0064;

   typedef enum logic [3:0]
   {
      ST_IDLE = 4'h1,
      ST_PROG = 4'h2,
      ST_RUN = 4'h4,
      ST_FINISH = 4'h8
   } seq_state_type;

endpackage : pulser_pkg

// [rtl/switch_events_if.sv]
// debounced switch events passed from the switch filter to the sequencer
// assumes both ends run on the same system clock
`timescale 1ns/1ps
interface switch_events_if;
   logic press;
   logic held;

   modport source
   (
      output press,
      output held
   );

   modport sink
   (
      input press,
      input held
   );
endinterface : switch_events_if

// [rtl/mode_table_rom.sv]
// 256-bit fixed mode table, eight words of 32 bits, registered read
// assumes the address is held steady while a mode runs
`timescale 1ns/1ps
module mode_table_rom
   import pulser_pkg::*;
(
   input wire logic i_clk,
   input wire logic [2:0] i_addr,
   output logic [31:0] o_data
);

   logic [31:0] word;

   always_comb
   begin
      case (i_addr)
         3'h1: word = MODE_CONT_100HZ;
         3'h2: word = MODE_BURST_100;
         3'h3: word = MODE_CONT_10HZ;
         3'h4: word = MODE_BURST_10;
         3'h5: word = MODE_CONT_1HZ;
         default: word = MODE_NONE;
      endcase
   end

   always_ff @(posedge i_clk)
   begin
      o_data <= word;
   end

endmodule : mode_table_rom

// [rtl/switch_conditioner.sv]
// synchronises and debounces the push switch, reports press and held level
// assumes i_tick is a one-cycle 100 Hz enable on the same clock
`timescale 1ns/1ps
module switch_conditioner
   import pulser_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_tick,
   input wire logic i_switch,
   switch_events_if.source ev
);

   logic sw_meta;
   logic sw_sync;
   logic level;
   logic level_d;
   logic [1:0] stable_cnt;
   wire differs = (sw_sync != level);

   always_ff @(posedge i_clk)
   begin
      sw_meta <= i_switch;
      sw_sync <= sw_meta;
   end

   // a change must persist over two ticks; bounces shorter than that vanish
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         level <= 1'b0;
         stable_cnt <= 2'h0;
      end
      else if (!differs)
         stable_cnt <= 2'h0;
      else if (i_tick && stable_cnt == DEBOUNCE_TICKS - 2'h1)
      begin
         level <= sw_sync;
         stable_cnt <= 2'h0;
      end
      else if (i_tick)
         stable_cnt <= stable_cnt + 2'h1;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         level_d <= 1'b0;
      else
         level_d <= level;
   end

   assign ev.press = level & ~level_d;
   assign ev.held = level;

endmodule : switch_conditioner

// [rtl/switch_programmed_pulse_sequencer.sv]
// top of the one-button pulse sequencer: programming, mode run, tip pulse, LED
// assumes i_switch, i_tip and i_overload are asynchronous pins; the tip pin
// is resolved outside from o_tip and o_tip_oe_n
`timescale 1ns/1ps

// What this block does
// - count push only within one second
// - hold over one second starts mode
// - latched switch runs mode as hold
// - release midburst still completes burst
// - programming pulses deducted from first burst
// - other release stops output, reprogram at once
// - released over one second clears pushes
// - LED flashes once per burst
// - controller tracks programming, running, idle reset
// - each press in idle or programming presets timing, fires pulse unless one is live
// - burst control starts, counts, stops bursts
// - one time base for rates, bursts
// - all timing but the pulse width from one 100 Hz tick
// - pulse drives tip opposite present level
// - overload sense ends pulse early
// - 256-bit fixed table sets mode behaviour
// - LED driver shows activity per mode
// - push count selects one of five modes
// - 100 burst: 100 pulses, every 2 s
// - 10 burst: 10 pulses, every 1 s
// - one-shot pulse about 10 us wide
module switch_programmed_pulse_sequencer
   import pulser_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYCLES_DEFAULT
)
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_switch,
   input wire logic i_tip,
   input wire logic i_overload,
   output logic o_tip,
   output logic o_tip_oe_n,
   output logic o_led,
   output logic o_running
);

   localparam logic [19:0] TICK_LAST = 20'(TICK_CYCLES - 1);

   function automatic logic [2:0] bump_count(input logic [2:0] cnt);
      bump_count = (cnt >= MAX_PUSHES) ? MAX_PUSHES : cnt + 3'h1;
   endfunction : bump_count

   switch_events_if ev ();

   seq_state_type state;
   seq_state_type next_state;
   logic [19:0] tick_cnt;
   logic [2:0] push_count;
   logic [6:0] hold_cnt;
   logic [6:0] gap_cnt;
   logic [31:0] mode_word;
   logic [7:0] rate_cnt;
   logic [7:0] frame_cnt;
   logic [7:0] burst_left;
   logic [7:0] led_cnt;
   logic [2:0] flash_cnt;
   logic [9:0] pulse_cnt;
   logic [1:0] pin_meta;
   logic [1:0] pin_sync;
   logic pulse_pol;

   // shared 100 Hz enable; a press restarts it so timing follows the push
   wire tick = (tick_cnt == TICK_LAST);

   switch_conditioner u_switch
   (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_tick(tick),
      .i_switch(i_switch),
      .ev(ev.source)
   );

   mode_table_rom u_table
   (
      .i_clk(i_clk),
      .i_addr(push_count),
      .o_data(mode_word)
   );

   // mode parameters decoded from the table word
   wire [7:0] rate_ticks = mode_word[FLD_RATE_LSB +: FLD_WIDTH];
   wire [7:0] burst_len = mode_word[FLD_LEN_LSB +: FLD_WIDTH];
   wire [7:0] repeat_ticks = mode_word[FLD_REPEAT_LSB +: FLD_WIDTH];
   wire [7:0] led_ticks = mode_word[FLD_LED_LSB +: FLD_WIDTH];
   wire burst_mode = (burst_len != 8'h00);

   wire tip_level = pin_sync[0];
   wire overload = pin_sync[1];
   wire running = (state == ST_RUN) || (state == ST_FINISH);
   wire programming = (state == ST_PROG);
   wire accept_press = ev.press && ((state == ST_IDLE) || programming);
   wire in_window = (gap_cnt < WINDOW_TICKS);
   wire [2:0] next_push = (programming && in_window) ? bump_count(push_count) : 3'h1;
   wire enter_run = programming && (next_state == ST_RUN);
   wire to_idle = (state != ST_IDLE) && (next_state == ST_IDLE);
   wire frame_wrap = (frame_cnt == repeat_ticks - 8'h01);
   wire rate_wrap = (rate_cnt == rate_ticks - 8'h01);
   wire [7:0] first_burst = burst_len - {5'h00, push_count};
   wire cont_fire = tick && (state == ST_RUN) && !burst_mode && rate_wrap;
   wire burst_fire = tick && running && burst_mode && (burst_left != 8'h00);
   wire fire = accept_press || cont_fire || burst_fire;
   wire pulse_end = overload || (pulse_cnt == PULSE_CYCLES - 10'h001);
   wire led_blink = (led_cnt < {1'b0, led_ticks[7:1]});
   wire next_led = (flash_cnt != 3'h0)
                   || (running && burst_mode && burst_left != 8'h00)
                   || ((state == ST_RUN) && !burst_mode && led_blink);

   // tip sense and overload sense come from pins
   always_ff @(posedge i_clk)
   begin
      pin_meta <= {i_overload, i_tip};
      pin_sync <= pin_meta;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst || ev.press || tick)
         tick_cnt <= 20'h00000;
      else
         tick_cnt <= tick_cnt + 20'h00001;
   end

   // mode controller
   always_comb
   begin
      next_state = state;
      case (state)
         ST_IDLE:
         begin
            if (accept_press)
               next_state = ST_PROG;
         end
         ST_PROG:
         begin
            if (tick && ev.held && hold_cnt == HOLD_TICKS)
               next_state = ST_RUN;
            else if (tick && !ev.held && gap_cnt == ERASE_TICKS)
               next_state = ST_IDLE;
         end
         ST_RUN:
         begin
            if (!ev.held && burst_mode && burst_left != 8'h00)
               next_state = ST_FINISH;
            else if (!ev.held)
               next_state = ST_IDLE;
         end
         ST_FINISH:
         begin
            if (burst_left == 8'h00)
               next_state = ST_IDLE;
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         state <= ST_IDLE;
      else
         state <= next_state;
   end

   // push count doubles as the table address; cleared on every return to idle
   always_ff @(posedge i_clk)
   begin
      if (i_rst || to_idle)
         push_count <= 3'h0;
      else if (accept_press)
         push_count <= next_push;
   end

   // hold time while pressed, gap time while released, both since last press
   always_ff @(posedge i_clk)
   begin
      if (i_rst || accept_press || !programming)
      begin
         hold_cnt <= 7'h00;
         gap_cnt <= 7'h00;
      end
      else if (tick && ev.held && hold_cnt != HOLD_TICKS)
         hold_cnt <= hold_cnt + 7'h01;
      else if (tick && !ev.held && gap_cnt != ERASE_TICKS)
         gap_cnt <= gap_cnt + 7'h01;
   end

   // continuous-rate divider
   always_ff @(posedge i_clk)
   begin
      if (i_rst || accept_press || enter_run || (tick && rate_wrap))
         rate_cnt <= 8'h00;
      else if (tick && running)
         rate_cnt <= rate_cnt + 8'h01;
   end

   // burst repeat frame
   always_ff @(posedge i_clk)
   begin
      if (i_rst || accept_press || enter_run || (tick && frame_wrap))
         frame_cnt <= 8'h00;
      else if (tick && running)
         frame_cnt <= frame_cnt + 8'h01;
   end

   // pulses left in the current burst; after release no new burst is loaded
   always_ff @(posedge i_clk)
   begin
      if (i_rst || accept_press)
         burst_left <= 8'h00;
      else if (enter_run)
         burst_left <= burst_mode ? first_burst : 8'h00;
      else if (tick && frame_wrap && state == ST_RUN && burst_mode)
         burst_left <= burst_len;
      else if (burst_fire)
         burst_left <= burst_left - 8'h01;
   end

   // indicator: short flash per press, blink in continuous modes
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         flash_cnt <= 3'h0;
      else if (accept_press)
         flash_cnt <= FLASH_TICKS;
      else if (tick && flash_cnt != 3'h0)
         flash_cnt <= flash_cnt - 3'h1;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst || !running || (tick && led_cnt == led_ticks - 8'h01))
         led_cnt <= 8'h00;
      else if (tick)
         led_cnt <= led_cnt + 8'h01;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_led <= 1'b0;
         o_running <= 1'b0;
      end
      else
      begin
         o_led <= next_led;
         o_running <= running;
      end
   end

   // output one-shot; a request during a live pulse is dropped, not queued
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_tip_oe_n <= 1'b1;
         pulse_pol <= 1'b0;
         pulse_cnt <= 10'h000;
      end
      else if (fire && o_tip_oe_n)
      begin
         o_tip_oe_n <= 1'b0;
         pulse_pol <= ~tip_level;
         pulse_cnt <= 10'h000;
      end
      else if (!o_tip_oe_n && pulse_end)
         o_tip_oe_n <= 1'b1;
      else if (!o_tip_oe_n)
         pulse_cnt <= pulse_cnt + 10'h001;
   end

   assign o_tip = pulse_pol;

endmodule : switch_programmed_pulse_sequencer

// [testbench/switch_programmed_pulse_sequencer_chk.sv]
// port assertions of the pulse sequencer
// assumes binding into the top, sharing its tick parameter
`timescale 1ns/1ps
module switch_programmed_pulse_sequencer_chk
   import pulser_pkg::*;
#(
   parameter int TICK_CYCLES = 20
)
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_switch,
   input wire logic i_tip,
   input wire logic i_overload,
   input wire logic o_tip,
   input wire logic o_tip_oe_n,
   input wire logic o_led,
   input wire logic o_running
);
   int low_cnt;
   int held_cnt;
   int rel_cnt;
   int idle_cnt;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);
   always_ff @(posedge i_clk)
   begin
      low_cnt <= (i_rst || o_tip_oe_n) ? 0 : low_cnt + 1;
      held_cnt <= (i_rst || !i_switch) ? 0 : held_cnt + 1;
      rel_cnt <= (i_rst || i_switch) ? 0 : rel_cnt + 1;
      idle_cnt <= (i_rst || o_running) ? 0 : idle_cnt + 1;
   end
   sequence s_drive_begin;
      $fell(o_tip_oe_n);
   endsequence
   sequence s_drive_end;
      $rose(o_tip_oe_n);
   endsequence
   property p_reset_quiet;
      $fell(i_rst) |-> o_tip_oe_n && !o_led && !o_running;
   endproperty
   property p_width_max;
      s_drive_end |-> low_cnt <= PULSE_CYCLES;
   endproperty
   property p_early_end;
      $rose(o_tip_oe_n) && low_cnt != PULSE_CYCLES |-> $past(i_overload);
   endproperty
   property p_overload;
      i_overload [*3] |=> o_tip_oe_n;
   endproperty
   property p_tip_level;
      s_drive_begin |-> o_tip != $past(i_tip);
   endproperty
   property p_tip_stable;
      !o_tip_oe_n && !$past(o_tip_oe_n) |-> $stable(o_tip);
   endproperty
   property p_run_start;
      $rose(o_running) |-> held_cnt >= 100 * TICK_CYCLES;
   endproperty
   property p_idle_quiet;
      rel_cnt > 210 * TICK_CYCLES |-> !o_running && o_tip_oe_n;
   endproperty
   property p_led_idle;
      rel_cnt > 8 * TICK_CYCLES && idle_cnt > 2 * TICK_CYCLES |-> !o_led;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("busy after reset");
   a_width_max: assert property (p_width_max) else $error("pulse too long");
   a_early_end: assert property (p_early_end) else $error("pulse cut short");
   a_overload: assert property (p_overload) else $error("overload ignored");
   a_tip_level: assert property (p_tip_level) else $error("pulse not opposite");
   a_tip_stable: assert property (p_tip_stable) else $error("drive level moved");
   a_run_start: assert property (p_run_start) else $error("run without hold");
   a_idle_quiet: assert property (p_idle_quiet) else $error("active when idle");
   a_led_idle: assert property (p_led_idle) else $error("indicator lit idle");
endmodule : switch_programmed_pulse_sequencer_chk

// [testbench/tip_node_model.sv]
// node under test at the tip: holds its own level unless the tip drives it
// assumes an active-low tip enable and one clock
`timescale 1ns/1ps
module tip_node_model
(
   input wire logic i_clk,
   input wire logic i_rest,
   input wire logic i_short,
   input wire logic i_drive,
   input wire logic i_drive_oe_n,
   output logic o_node,
   output logic o_overload
);
   int drive_cnt;
   // the node is driven by its own circuit, so a released tip shows that level
   assign o_node = i_drive_oe_n ? i_rest : i_drive;
   // a heavy load passes the charge limit two clocks into a pulse
   assign o_overload = i_short && !i_drive_oe_n && drive_cnt >= 2;
   always_ff @(posedge i_clk)
   begin
      drive_cnt <= i_drive_oe_n ? 0 : drive_cnt + 1;
   end
endmodule : tip_node_model

// [testbench/switch_programmed_pulse_sequencer_test.sv]
// self-checking bench of the pulse sequencer with a tip node model
// assumes a short tick so that second-long windows take few cycles
`timescale 1ns/1ps
module switch_programmed_pulse_sequencer_test
   import pulser_pkg::*;
;
   localparam int T = 20;
   logic i_clk;
   logic i_rst;
   logic i_switch;
   logic rest;
   logic short_load;
   logic tip;
   logic overload;
   logic o_tip;
   logic o_tip_oe_n;
   logic o_led;
   logic o_running;
   int n_errors;
   int samples_checked;
   int cycles;
   int n;
   logic lvl;
   switch_programmed_pulse_sequencer #(.TICK_CYCLES(T)) i_dut (.i_clk(i_clk), .i_rst(i_rst),
      .i_switch(i_switch), .i_tip(tip), .i_overload(overload), .o_tip(o_tip),
      .o_tip_oe_n(o_tip_oe_n), .o_led(o_led), .o_running(o_running));
   tip_node_model i_node (.i_clk(i_clk), .i_rest(rest), .i_short(short_load), .i_drive(o_tip),
      .i_drive_oe_n(o_tip_oe_n), .o_node(tip), .o_overload(overload));
   initial
   begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   // whole run needs about 35000 cycles
   always @(posedge i_clk)
   begin
      cycles = cycles + 1;
      if (cycles == 60000)
      begin
         n_errors++;
         results();
      end
   end
   task automatic chk_bit(input string name, input logic exp, input logic got);
      samples_checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("ERROR %s expected %b seen %b", name, exp, got);
      end
   endtask : chk_bit
   task automatic chk_num(input string name, input int lo, input int hi, input int got);
      samples_checked++;
      if (got < lo || got > hi)
      begin
         n_errors++;
         $display("ERROR %s expected %0d..%0d seen %0d", name, lo, hi, got);
      end
   endtask : chk_num
   task automatic ticks(input int k);
      repeat (k * T) @(posedge i_clk);
   endtask : ticks
   task automatic push(input int k);
      @(posedge i_clk);
      i_switch <= 1'b1;
      ticks(k);
      i_switch <= 1'b0;
   endtask : push
   // low cycles of the next pulse, and its drive level
   task automatic pulse_len(output int len, output logic drv);
      int w;
      len = 0;
      w = 0;
      while (o_tip_oe_n !== 1'b0 && w < 10 * T)
      begin
         @(posedge i_clk);
         w++;
      end
      drv = o_tip;
      while (o_tip_oe_n === 1'b0 && len < 2000)
      begin
         @(posedge i_clk);
         len++;
      end
   endtask : pulse_len
   task automatic wait_run(input logic v, input int max, output int w);
      w = 0;
      while (o_running !== v && w < max)
      begin
         @(posedge i_clk);
         w++;
      end
   endtask : wait_run
   task automatic t_single;
      for (int i = 0; i < 2; i++)
      begin
         rest <= logic'(i);
         fork
            push(5);
            pulse_len(n, lvl);
         join
         chk_bit("tip level", ~logic'(i), lvl);
         chk_num("pulse width", 1000, 1000, n);
         ticks(110);
         chk_bit("running", 1'b0, o_running);
      end
      $display("single pulse done");
   endtask : t_single
   task automatic t_overload;
      short_load <= 1'b1;
      fork
         push(5);
         pulse_len(n, lvl);
      join
      short_load <= 1'b0;
      chk_num("loaded width", 3, 8, n);
      ticks(110);
      $display("overload done");
   endtask : t_overload
   task automatic t_cont;
      int p;
      @(posedge i_clk);
      i_switch <= 1'b1;
      wait_run(1'b1, 130 * T, n);
      chk_num("run start", 100 * T, 110 * T, n);
      p = 0;
      repeat (60 * T)
      begin
         @(posedge i_clk);
         p += int'(o_tip_oe_n === 1'b0 && i_dut.o_tip_oe_n === 1'b0 && $isunknown(n) == 0);
      end
      chk_num("driving cycles", 1000, 1200, p);
      i_switch <= 1'b0;
      wait_run(1'b0, 10 * T, n);
      chk_num("stop delay", 1, 5 * T, n);
      // a press during a live pulse fires nothing, so let the last train pulse end
      while (o_tip_oe_n !== 1'b1)
      begin
         @(posedge i_clk);
      end
      fork
         push(5);
         pulse_len(n, lvl);
      join
      chk_num("new pulse", 1000, 1000, n);
      ticks(110);
      $display("continuous done");
   endtask : t_cont
   task automatic t_burst;
      push(5);
      ticks(5);
      i_switch <= 1'b1;
      wait_run(1'b1, 130 * T, n);
      chk_num("burst start", 100 * T, 110 * T, n);
      ticks(10);
      i_switch <= 1'b0;
      ticks(20);
      chk_bit("running", 1'b1, o_running);
      chk_bit("led", 1'b1, o_led);
      wait_run(1'b0, 100 * T, n);
      chk_num("burst end", 50 * T, 80 * T, n);
      ticks(220);
      chk_bit("idle", 1'b0, o_running);
      chk_bit("led idle", 1'b0, o_led);
      $display("burst done");
   endtask : t_burst
   // four pushes then a hold select the 1 Hz train; pulses are shorter than its period
   task automatic t_slow;
      int p;
      logic prev;
      repeat (4)
      begin
         push(5);
         ticks(5);
      end
      i_switch <= 1'b1;
      wait_run(1'b1, 130 * T, n);
      chk_num("slow start", 100 * T, 110 * T, n);
      p = 0;
      prev = 1'b1;
      repeat (250 * T)
      begin
         @(posedge i_clk);
         p += int'(prev === 1'b1 && o_tip_oe_n === 1'b0);
         prev = o_tip_oe_n;
      end
      chk_num("slow pulses", 2, 3, p);
      i_switch <= 1'b0;
      wait_run(1'b0, 10 * T, n);
      chk_num("slow stop", 1, 5 * T, n);
      ticks(110);
      $display("slow rate done");
   endtask : t_slow
   task automatic results;
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
      begin
         $display("TEST PASSED");
      end
      else
      begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : results
   initial
   begin
      i_rst = 1'b1;
      i_switch = 1'b0;
      rest = 1'b0;
      short_load = 1'b0;
      n_errors = 0;
      samples_checked = 0;
      cycles = 0;
      repeat (16) @(posedge i_clk);
      i_rst <= 1'b0;
      @(posedge i_clk);
      @(posedge i_clk);
      chk_bit("tip enable", 1'b1, o_tip_oe_n);
      chk_bit("running", 1'b0, o_running);
      t_single();
      t_overload();
      t_cont();
      t_burst();
      t_slow();
      results();
   end
endmodule : switch_programmed_pulse_sequencer_test
bind switch_programmed_pulse_sequencer switch_programmed_pulse_sequencer_chk
   #(.TICK_CYCLES(TICK_CYCLES)) i_chk (.i_clk(i_clk), .i_rst(i_rst), .i_switch(i_switch),
   .i_tip(i_tip), .i_overload(i_overload), .o_tip(o_tip), .o_tip_oe_n(o_tip_oe_n),
   .o_led(o_led), .o_running(o_running));
